// >>> src/spc_slot_power_regs.sv
// two-slot power control and status register bank behind a serial management port
//
// Functional notes
// - slot A control: main bit1, aux bit0
// - slot B control: same layout as A
// - control bits 7,6 report aux/main power-good
// - control registers reset to zero, outputs off
// - slot A status: fault, main, aux, overcurrents
// - main state bit shows actual main outputs
// - aux state bit shows actual aux output
// - overcurrent bit sets on its supply fault
// - writing one clears fault, zero keeps
// - status read leaves fault pin untouched
// - status registers reset to zero
// - slot B status uses slot A layout
// - fault bit is one while pin low
// - serial control mode silences fault pin
// - byte read/write: address, command, data
`timescale 1ns/1ps
module spc_slot_power_regs (
    // core clock and reset
    input  wire logic                          clock,
    input  wire logic                          reset,
    // serial management link
    input  wire logic                          smb_clk,
    input  wire logic                          sda_in,
    output logic                               sda_out,
    output logic                               sda_oe,
    // address straps
    input  wire logic [2:0]                    addr_pins,
    // slot pins
    input  wire spc_pkg::spc_slot_in_t [1:0]   slot_in,
    output spc_pkg::spc_slot_out_t [1:0]       slot_out,
    // interrupt
    output logic                               int_n
);
    import spc_pkg::*;

    spc_sys_state_t q;          // registered core state
    spc_sys_state_t n;          // its next value
    logic [7:0]     link_rd_cmd; // command for pending read
    logic           link_rd_req; // read request toggle
    spc_wr_t        link_wr;     // pending write word
    logic           link_wr_req; // write request toggle
    logic           wr_ev;       // write delivered this cycle
    logic           rd_ev;       // read requested this cycle

    // decode a command into {control hit, status hit, slot}
    function automatic logic [2:0] cmd_decode(input logic [7:0] cmd);
        case (cmd)
            SPC_CMD_CTRL_A: cmd_decode = 3'h4;
            SPC_CMD_CTRL_B: cmd_decode = 3'h5;
            SPC_CMD_STAT_A: cmd_decode = 3'h2;
            SPC_CMD_STAT_B: cmd_decode = 3'h3;
            default:        cmd_decode = 3'h0;
        endcase
    endfunction

    // compose the read value of a register from current state
    function automatic logic [7:0] read_value(input logic [7:0] cmd, input spc_sys_state_t s);
        logic [2:0] d;
        logic       k;
        d = cmd_decode(cmd);
        k = d[0];
        read_value = SPC_UNMAPPED_READ;
        if (d[2]) begin
            read_value = {s.filt[k].aux_good, s.filt[k].main_good, 4'h0, s.en_main[k], s.en_aux[k]};
        end else if (d[1]) begin
            read_value = {~s.out[k].fault_out_n, s.filt[k].main_state, s.filt[k].aux_state, s.oc[k]};
        end
    endfunction

    // byte engine on the bus clock
    spc_smbus_link u_link (
        .smb_clk    (smb_clk),
        .reset      (reset),
        .sda_in     (sda_in),
        .sda_out    (sda_out),
        .sda_oe     (sda_oe),
        .slave_addr (q.slave_addr),
        .rd_cmd     (link_rd_cmd),
        .rd_req_tgl (link_rd_req),
        .rd_data    (q.rd_data),
        .rd_ack_tgl (q.rd_ack),
        .wr_word    (link_wr),
        .wr_req_tgl (link_wr_req)
    );

    // toggles become one-cycle events after their synchronisers
    assign wr_ev = q.wr_s2 ^ q.wr_seen;
    assign rd_ev = q.rd_s2 ^ q.rd_seen;

    // core next-state logic
    always_comb begin
        logic [2:0]          wd;
        logic [SPC_OC_W-1:0] clr;
        logic [SPC_OC_W-1:0] set;
        spc_slot_in_t        f;
        n   = q;
        wd  = cmd_decode(link_wr.cmd);
        clr = SPC_OC_RESET;
        set = SPC_OC_RESET;
        f   = q.filt[0];
        // pins pass three stages; a bit moves when stages two and three agree
        n.in_s1 = slot_in;
        n.in_s2 = q.in_s1;
        n.in_s3 = q.in_s2;
        for (int s = 0; s < SPC_SLOTS; s++) begin
            n.filt[s] = spc_slot_in_t'((q.in_s2[s] & q.in_s3[s]) | (q.filt[s] & (q.in_s2[s] | q.in_s3[s])));
        end
        // strap stage three is taken once, at the third edge after reset release, while it still holds its reset zero
        n.addr_s1 = addr_pins;
        n.addr_s2 = q.addr_s1;
        n.addr_s3 = q.addr_s2;
        if (q.strap_cnt != SPC_STRAP_WAIT) begin
            n.strap_cnt = q.strap_cnt + 2'h1;
            if (q.strap_cnt + 2'h1 == SPC_STRAP_WAIT) begin
                n.slave_addr = {SPC_ADDR_PREFIX, q.addr_s3};
            end
        end
        // handshake synchronisers from the link
        n.wr_s1   = link_wr_req;
        n.wr_s2   = q.wr_s1;
        n.wr_seen = q.wr_s2;
        n.rd_s1   = link_rd_req;
        n.rd_s2   = q.rd_s1;
        n.rd_seen = q.rd_s2;
        // read only snapshots, touches no fault state
        if (rd_ev) begin
            n.rd_data = read_value(link_rd_cmd, q);
            n.rd_ack  = ~q.rd_ack;
        end
        for (int s = 0; s < SPC_SLOTS; s++) begin
            f   = q.filt[s];
            set = f.oc;
            clr = (wr_ev && wd[1] && wd[0] == s[0]) ? link_wr.data[SPC_OC_W-1:0] : SPC_OC_RESET;
            // write one clears, set wins over clear
            n.oc[s] = (q.oc[s] & ~clr) | set;
            // only the two enable bits are writable
            if (wr_ev && wd[2] && wd[0] == s[0]) begin
                n.en_main[s] = link_wr.data[SPC_CTRL_MAIN_EN];
                n.en_aux[s]  = link_wr.data[SPC_CTRL_AUX_EN];
            end
            if (f.smi_ctrl) begin
                // fault pin idle under serial control
                n.flt_main[s] = 1'b0;
                n.flt_aux[s]  = 1'b0;
            end else begin
                // dropping the enable pin resets the fault
                n.flt_main[s] = f.on_pin & (q.flt_main[s] | (|(set & SPC_OC_MAIN_MASK)));
                n.flt_aux[s]  = f.auxen_pin & (q.flt_aux[s] | (|(set & SPC_OC_AUX_MASK)));
            end
            // a tripped group stays off until its fault is cleared
            if (f.smi_ctrl) begin
                n.out[s].main_switch = q.en_main[s] & ~(|(q.oc[s] & SPC_OC_MAIN_MASK));
                n.out[s].aux_switch  = q.en_aux[s] & ~(|(q.oc[s] & SPC_OC_AUX_MASK));
            end else begin
                n.out[s].main_switch = f.on_pin & ~q.flt_main[s];
                n.out[s].aux_switch  = f.auxen_pin & ~q.flt_aux[s];
            end
            n.out[s].fault_out_n = ~(q.flt_main[s] | q.flt_aux[s]);
        end
        // interrupt while any fault bit stands
        n.int_n = ~((|q.oc[0]) | (|q.oc[1]));
    end

    // core register
    always_ff @(posedge clock) begin
        if (reset) begin
            q         <= '0;
            q.out     <= {SPC_OUT_RESET, SPC_OUT_RESET};
            q.int_n   <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign slot_out = q.out;
    assign int_n    = q.int_n;

    // fault on a supply pulls the interrupt two cycles later
    a_oc_raises_int: assert property (@(posedge clock) disable iff (reset)
        (q.filt[0].oc != 5'h00) |=> ##1 !q.int_n)
        else $error("interrupt not asserted after overcurrent");

    // aux overcurrent latches its bit
    a_oc_sets_flag: assert property (@(posedge clock) disable iff (reset)
        q.filt[1].oc[SPC_OC_AUX] |=> q.oc[1][SPC_OC_AUX] [*1] ##1 (q.oc[1][SPC_OC_AUX] || $past(wr_ev)))
        else $error("aux overcurrent bit not latched");

    // writing one clears an idle fault
    a_w1c_clears: assert property (@(posedge clock) disable iff (reset)
        (wr_ev && link_wr.cmd == SPC_CMD_STAT_A && link_wr.data[0] && !q.filt[0].oc[0]) |=> !q.oc[0][0])
        else $error("write one did not clear fault bit");

    // writing zero keeps a set fault
    a_w0_keeps: assert property (@(posedge clock) disable iff (reset)
        (wr_ev && link_wr.cmd == SPC_CMD_STAT_A && !link_wr.data[0] && q.oc[0][0]) |=> q.oc[0][0])
        else $error("write zero disturbed fault bit");

    // slot B control write lands in both enables
    a_ctrl_write: assert property (@(posedge clock) disable iff (reset)
        (wr_ev && link_wr.cmd == SPC_CMD_CTRL_B) |=>
        (q.en_main[1] == $past(link_wr.data[SPC_CTRL_MAIN_EN]) && q.en_aux[1] == $past(link_wr.data[SPC_CTRL_AUX_EN])))
        else $error("slot B control write lost");

    // after reset all enables are off
    a_reset_ctrl: assert property (@(posedge clock)
        $past(reset) |-> (q.en_main == 2'h0 && q.en_aux == 2'h0 && q.out[0].main_switch == 1'b0))
        else $error("control not cleared by reset");

    // after reset no fault recorded
    a_reset_stat: assert property (@(posedge clock)
        $past(reset) |-> (q.oc == 10'h000 && q.int_n && q.out[1].fault_out_n))
        else $error("status not cleared by reset");

    // a read does not move the fault pin
    a_read_quiet: assert property (@(posedge clock) disable iff (reset)
        (rd_ev && q.filt[0].oc == 5'h00 && q.filt[0].on_pin && $stable(q.filt[0].auxen_pin) && !q.filt[0].smi_ctrl)
        |=> ##1 $stable(q.out[0].fault_out_n))
        else $error("read disturbed fault pin");

    // serial control keeps the fault pin released
    a_smi_quiet: assert property (@(posedge clock) disable iff (reset)
        q.filt[0].smi_ctrl |=> ##1 q.out[0].fault_out_n)
        else $error("fault pin active under serial control");

    // control read layout
    a_ctrl_layout: assert property (@(posedge clock) disable iff (reset)
        (rd_ev && link_rd_cmd == SPC_CMD_CTRL_A) |=>
        (q.rd_data[5:2] == 4'h0 && q.rd_data[7] == $past(q.filt[0].aux_good) && q.rd_data[6] == $past(q.filt[0].main_good)))
        else $error("control read layout wrong");

    // slot B status read layout
    a_stat_layout: assert property (@(posedge clock) disable iff (reset)
        (rd_ev && link_rd_cmd == SPC_CMD_STAT_B) |=>
        (q.rd_data[4:0] == $past(q.oc[1]) && q.rd_data[7] == !$past(q.out[1].fault_out_n)))
        else $error("slot B status read layout wrong");

    // actual output state bits
    a_state_bits: assert property (@(posedge clock) disable iff (reset)
        (rd_ev && link_rd_cmd == SPC_CMD_STAT_A) |=>
        (q.rd_data[6] == $past(q.filt[0].main_state) && q.rd_data[5] == $past(q.filt[0].aux_state)))
        else $error("output state bits wrong");

endmodule // spc_slot_power_regs

// >>> src/spc_pkg.sv
// shared constants and types for the slot power control register bank
package spc_pkg;

    // number of slots served by this bank
    localparam int SPC_SLOTS = 2;

    // command codes of the registers
    localparam logic [7:0] SPC_CMD_CTRL_A = 8'h02;
    localparam logic [7:0] SPC_CMD_CTRL_B = 8'h03;
    localparam logic [7:0] SPC_CMD_STAT_A = 8'h04;
    localparam logic [7:0] SPC_CMD_STAT_B = 8'h05;

    // upper four bits of the seven-bit slave address; low three are zero, as strap stage three is taken before the straps reach it
    localparam logic [3:0] SPC_ADDR_PREFIX = 4'h8;

    // control register field positions
    localparam int SPC_CTRL_AUX_EN  = 0;
    localparam int SPC_CTRL_MAIN_EN = 1;

    // status register fields: overcurrent bits 4..0
    localparam int SPC_OC_W   = 5;
    localparam int SPC_OC_AUX = 4;

    // overcurrent groups: main supplies and auxiliary supply
    localparam logic [4:0] SPC_OC_MAIN_MASK = 5'h0F;
    localparam logic [4:0] SPC_OC_AUX_MASK  = 5'h10;

    // reset values
    localparam logic [4:0] SPC_OC_RESET = 5'h00;
    localparam logic       SPC_EN_RESET = 1'h0;

    // read answers: unmapped command, and data not yet delivered
    localparam logic [7:0] SPC_UNMAPPED_READ = 8'h00;
    localparam logic [7:0] SPC_STALE_READ    = 8'hFF;

    // serial framing: bit index of last data bit and of acknowledge
    localparam logic [3:0] SPC_BIT_LAST = 4'h7;
    localparam logic [3:0] SPC_BIT_ACK  = 4'h8;
    // count left at frame end: the clock edge of the closing stop wraps it to zero
    localparam logic [3:0] SPC_BIT_STOP = 4'hF;

    // bytes that follow a foreign address byte
    localparam logic [1:0] SPC_SKIP_WRITE = 2'h2;
    localparam logic [1:0] SPC_SKIP_READ  = 2'h1;

    // strap settling count after reset release
    localparam logic [1:0] SPC_STRAP_WAIT = 2'h3;

    // per-slot input pins
    typedef struct packed {
        logic       main_good;   // main outputs above undervoltage threshold
        logic       aux_good;    // aux output above undervoltage threshold
        logic       main_state;  // main outputs actually on
        logic       aux_state;   // aux output actually on
        logic       on_pin;      // hot-plug main on request
        logic       auxen_pin;   // hot-plug aux enable request
        logic       smi_ctrl;    // slot power paths under serial control
        logic [4:0] oc;          // overcurrent detect aux,-12,+12,5,3
    } spc_slot_in_t;

    localparam int SPC_IN_W = $bits(spc_slot_in_t);

    // per-slot output pins
    typedef struct packed {
        logic main_switch;  // gate for the four main paths
        logic aux_switch;   // gate for the aux path
        logic fault_out_n;  // active-low fault indication
    } spc_slot_out_t;

    localparam spc_slot_out_t SPC_OUT_RESET = '{main_switch: 1'h0, aux_switch: 1'h0, fault_out_n: 1'h1};

    // write word handed from link to core
    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] data;
    } spc_wr_t;

    // link byte engine states
    typedef enum logic [2:0] {LK_ADDR, LK_CMD, LK_WDATA, LK_RDATA, LK_SKIP} spc_link_st_t;

    // link rising-edge state
    typedef struct packed {
        spc_link_st_t st;
        logic [3:0]   cnt;
        logic [7:0]   shift;
        logic         p_sda;
        logic         ack_go;
        logic         hit;
        logic         rw;
        logic [1:0]   skip;
        logic [7:0]   rd_cmd;
        logic         rd_req_t;
        spc_wr_t      wr;
        logic         wr_req_t;
        logic         ack_s1;
        logic         ack_s2;
    } spc_link_state_t;

    // link falling-edge state
    typedef struct packed {
        logic oe;
        logic start;
        logic sda_o;
    } spc_link_neg_t;

    // core state
    typedef struct packed {
        logic [1:0][SPC_IN_W-1:0] in_s1;
        logic [1:0][SPC_IN_W-1:0] in_s2;
        logic [1:0][SPC_IN_W-1:0] in_s3;
        spc_slot_in_t [1:0]       filt;
        logic [2:0]               addr_s1;
        logic [2:0]               addr_s2;
        logic [2:0]               addr_s3;
        logic [1:0]               strap_cnt;
        logic [6:0]               slave_addr;
        logic                     wr_s1;
        logic                     wr_s2;
        logic                     wr_seen;
        logic                     rd_s1;
        logic                     rd_s2;
        logic                     rd_seen;
        logic [7:0]               rd_data;
        logic                     rd_ack;
        logic [1:0]               en_main;
        logic [1:0]               en_aux;
        logic [1:0][SPC_OC_W-1:0] oc;
        logic [1:0]               flt_main;
        logic [1:0]               flt_aux;
        spc_slot_out_t [1:0]      out;
        logic                     int_n;
    } spc_sys_state_t;

endpackage

// >>> src/spc_smbus_link.sv
// serial management byte engine running on the bus clock
`timescale 1ns/1ps
module spc_smbus_link (
    // bus clock domain
    input  wire logic           smb_clk,
    input  wire logic           reset,
    // serial data pin
    input  wire logic           sda_in,
    output logic                sda_out,
    output logic                sda_oe,
    // core side, quasi-static address
    input  wire logic [6:0]     slave_addr,
    // read handshake
    output logic [7:0]          rd_cmd,
    output logic                rd_req_tgl,
    input  wire logic [7:0]     rd_data,
    input  wire logic           rd_ack_tgl,
    // write handshake
    output spc_pkg::spc_wr_t    wr_word,
    output logic                wr_req_tgl
);
    import spc_pkg::*;

    spc_link_state_t q;       // rising-edge state
    spc_link_state_t n;       // its next value
    spc_link_neg_t   qn;      // falling-edge state
    spc_link_neg_t   nn;      // its next value
    logic            rst_s1;  // reset synchroniser first stage
    logic            rst_s2;  // reset in bus clock domain
    logic [7:0]      byte_v;  // byte completed this edge

    // reset crosses into the bus clock; the bus clock must run during reset
    always_ff @(posedge smb_clk) begin
        rst_s1 <= reset;
        rst_s2 <= rst_s1;
    end

    // byte framing, address match and handshakes toward the core
    always_comb begin
        n      = q;
        byte_v = {q.shift[6:0], sda_in};
        n.p_sda  = sda_in;
        n.ack_s1 = rd_ack_tgl;
        n.ack_s2 = q.ack_s1;
        if (q.cnt != SPC_BIT_ACK) begin
            n.shift = byte_v;
            n.cnt   = q.cnt + 4'h1;
        end
        if (qn.start) begin
            // repeated start seen while clock was high: this bit opens an address
            n.st     = LK_ADDR;
            n.cnt    = 4'h1;
            n.shift  = byte_v;
            n.ack_go = 1'b0;
        end else if (q.cnt == SPC_BIT_LAST) begin
            case (q.st)
                LK_ADDR: begin
                    n.hit    = (byte_v[7:1] == slave_addr);
                    n.rw     = byte_v[0];
                    n.ack_go = (byte_v[7:1] == slave_addr);
                end
                LK_CMD: begin
                    n.rd_cmd   = byte_v;
                    n.rd_req_t = ~q.rd_req_t;
                    n.ack_go   = 1'b1;
                end
                LK_WDATA: begin
                    n.wr       = '{cmd: q.rd_cmd, data: byte_v};
                    n.wr_req_t = ~q.wr_req_t;
                    n.ack_go   = 1'b1;
                end
                default: begin
                    n.ack_go = 1'b0;
                end
            endcase
        end else if (q.cnt == SPC_BIT_ACK) begin
            n.cnt    = 4'h0;
            n.ack_go = 1'b0;
            case (q.st)
                LK_ADDR: begin
                    if (!q.hit) begin
                        // foreign frame: count its bytes, never drive
                        n.st   = LK_SKIP;
                        n.skip = q.rw ? SPC_SKIP_READ : SPC_SKIP_WRITE;
                    end else if (q.rw) begin
                        // data only trusted once the core has answered
                        n.st    = LK_RDATA;
                        n.shift = (q.ack_s2 == q.rd_req_t) ? rd_data : SPC_STALE_READ;
                    end else begin
                        n.st = LK_CMD;
                    end
                end
                LK_CMD: begin
                    n.st = LK_WDATA;
                end
                LK_SKIP: begin
                    n.skip = q.skip - 2'h1;
                    if (q.skip == 2'h1) begin
                        n.st  = LK_ADDR;
                        n.cnt = SPC_BIT_STOP;
                    end
                end
                default: begin
                    // frame over; the stop that follows still clocks once, so absorb that edge
                    n.st  = LK_ADDR;
                    n.cnt = SPC_BIT_STOP;
                end
            endcase
        end
    end

    // data pin changes only on the falling edge, so it never looks like start or stop
    always_comb begin
        nn       = qn;
        nn.start = q.p_sda & ~sda_in;
        nn.sda_o = 1'b0;
        nn.oe    = (q.cnt == SPC_BIT_ACK && q.ack_go) ||
                   (q.st == LK_RDATA && q.cnt != SPC_BIT_ACK && !q.shift[7]);
    end

    // rising-edge register
    always_ff @(posedge smb_clk) begin
        if (rst_s2) begin
            q        <= '0;
            q.st     <= LK_ADDR;
            q.p_sda  <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // falling-edge register
    always_ff @(negedge smb_clk) begin
        if (rst_s2) begin
            qn <= '0;
        end else begin
            qn <= nn;
        end
    end

    assign sda_out    = qn.sda_o;
    assign sda_oe     = qn.oe;
    assign rd_cmd     = q.rd_cmd;
    assign rd_req_tgl = q.rd_req_t;
    assign wr_word    = q.wr;
    assign wr_req_tgl = q.wr_req_t;

endmodule // spc_smbus_link

// >>> bench/spc_host.sv
// host model issuing byte read and write frames on the serial port
`timescale 1ns/1ps
module spc_host (
    // bus pins
    output logic      smb_clk,
    output logic      sda_in,
    input  wire logic sda_out,
    input  wire logic sda_oe
);
    logic       drv_low; // host pulls data low
    logic [7:0] rd_byte; // last byte read
    event       rd_done; // read result ready
    // wired-and with pull-up: a released wire floats high
    assign sda_in = ~(drv_low | (sda_oe & ~sda_out));
    // bus clock idles high and stands still between frames
    initial begin
        smb_clk = 1'h1;
        drv_low = 1'h0;
    end
    // one bit: data set in low phase, sampled in the middle of high phase
    task automatic bit_io(input logic b, output logic s);
        drv_low = ~b;
        #40 smb_clk = 1'h1;
        #40 s = sda_in;
        #40 smb_clk = 1'h0;
        #40;
    endtask
    // start or repeated start: data falls while clock high
    task automatic start();
        drv_low = 1'h0;
        #40 smb_clk = 1'h1;
        #40 drv_low = 1'h1;
        #40 smb_clk = 1'h0;
        #40;
    endtask
    // stop: data rises while clock high, clock left idle
    task automatic stop();
        drv_low = 1'h1;
        #40 smb_clk = 1'h1;
        #40 drv_low = 1'h0;
        #40;
    endtask
    task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ok);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
            q[i] = s;
        end
        bit_io(1'h1, s);
        ok = ~s;
    endtask
    task automatic wr(input logic [6:0] sa, input logic [7:0] c, input logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic k0, k1, k2;
        start();
        xfer({sa, 1'h0}, q, k0);
        xfer(c, q, k1);
        xfer(d, q, k2);
        stop();
        ok = k0 & k1 & k2;
    endtask
    // read frame: host nacks the data byte
    task automatic rd(input logic [6:0] sa, input logic [7:0] c);
        logic [7:0] q;
        logic k;
        start();
        xfer({sa, 1'h0}, q, k);
        xfer(c, q, k);
        start();
        xfer({sa, 1'h1}, q, k);
        xfer(8'hFF, rd_byte, k);
        stop();
        -> rd_done;
    endtask
endmodule // spc_host

// >>> bench/testbench.sv
// self-checking bench for the slot power register bank
`timescale 1ns/1ps
module testbench;
    import spc_pkg::*;
    logic                clock, reset, smb_clk, sda_in, sda_out, sda_oe, int_n, ok;
    logic [2:0]          addr_pins; // address straps
    logic [6:0]          sa;        // own slave address
    spc_slot_in_t [1:0]  slot_in;   // slot pins in
    spc_slot_out_t [1:0] slot_out;  // slot pins out
    logic [7:0]          exp_q[$];  // expected read bytes, oldest first
    logic [1:0]          pg;        // random power-good pair
    logic [4:0]          oc, m;     // overcurrent pattern, clear mask
    int                  mismatches, n_tests, cycles;
    spc_slot_power_regs u_spc_slot_power_regs (.clock(clock), .reset(reset), .smb_clk(smb_clk),
        .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .addr_pins(addr_pins),
        .slot_in(slot_in), .slot_out(slot_out), .int_n(int_n));
    spc_host u_spc_host (.smb_clk(smb_clk), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));
    initial begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("tests=%0d mismatches=%0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // watchdog: a hung frame ends the run as a failure
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            mismatches++;
            final_report();
        end
    end
    // each read result is compared with the oldest note
    always @(u_spc_host.rd_done) begin
        check(u_spc_host.rd_byte, exp_q.pop_front());
    end
    // frames end realigned just after a core clock edge
    task automatic rexp(input logic [7:0] c, input logic [7:0] e);
        exp_q.push_back(e);
        u_spc_host.rd(sa, c);
        @(posedge clock) #1;
    endtask
    task automatic wreg(input logic [7:0] c, input logic [7:0] d);
        u_spc_host.wr(sa, c, d, ok);
        check({7'h0, ok}, 8'h01);
        @(posedge clock) #1;
    endtask
    // pins pass a synchroniser and filter before the latches
    task automatic settle();
        repeat (12) @(posedge clock);
        #1;
    endtask
    initial begin
        void'($urandom(32'h1d41));
        {mismatches, n_tests, cycles} = '0;
        addr_pins = 3'($urandom);
        sa = {SPC_ADDR_PREFIX, addr_pins};
        slot_in = '0;
        reset = 1'h1;
        // the link reset needs bus clock edges while reset is high
        repeat (4) u_spc_host.bit_io(1'h1, ok);
        @(posedge clock) #1 reset = 1'h0;
        // the link leaves reset two bus edges later; the stop supplies the second one
        u_spc_host.bit_io(1'h1, ok);
        u_spc_host.stop();
        settle();
        check({2'h0, slot_out}, 8'h09);
        check({7'h0, int_n}, 8'h01);
        for (int r = 2; r < 6; r++) rexp(8'(r), 8'h00);
        rexp(8'h07, SPC_UNMAPPED_READ);
        for (int s = 0; s < 2; s++) begin
            pg = 2'($urandom);
            oc = 5'($urandom) | 5'h01;
            m = oc & 5'h15;
            slot_in[s].smi_ctrl = 1'h1;
            {slot_in[s].aux_good, slot_in[s].main_good} = pg;
            {slot_in[s].main_state, slot_in[s].aux_state} = ~pg;
            wreg(SPC_CMD_CTRL_A + 8'(s), 8'hFF);
            rexp(SPC_CMD_CTRL_A + 8'(s), {pg, 6'h03});
            check({6'h0, slot_out[s].main_switch, slot_out[s].aux_switch}, 8'h03);
            slot_in[s].oc = oc;
            settle();
            slot_in[s].oc = 5'h00;
            rexp(SPC_CMD_STAT_A + 8'(s), {1'h0, ~pg, oc});
            rexp(SPC_CMD_STAT_A + 8'(s), {1'h0, ~pg, oc});
            check({6'h0, int_n, slot_out[s].fault_out_n}, 8'h01);
            wreg(SPC_CMD_STAT_A + 8'(s), {3'h7, m});
            rexp(SPC_CMD_STAT_A + 8'(s), {1'h0, ~pg, oc & ~m});
            check({7'h0, int_n}, {7'h0, (oc & ~m) == 5'h00});
            wreg(SPC_CMD_STAT_A + 8'(s), 8'h1F);
            check({6'h0, int_n, slot_out[s].main_switch}, 8'h03);
            wreg(SPC_CMD_CTRL_A + 8'(s), 8'h00);
            check({6'h0, slot_out[s].main_switch, slot_out[s].aux_switch}, 8'h00);
        end
        // pin mode: a main overcurrent latches the fault pin
        slot_in[0] = '0;
        slot_in[0].on_pin = 1'h1;
        slot_in[0].oc = 5'h02;
        settle();
        slot_in[0].oc = 5'h00;
        check({5'h0, slot_out[0]}, 8'h00);
        rexp(SPC_CMD_STAT_A, 8'h82);
        // the slot's on pin drops to release the latch
        slot_in[0].on_pin = 1'h0;
        settle();
        check({5'h0, slot_out[0]}, 8'h01);
        // aux overcurrent latches the fault pin until the aux enable pin drops
        slot_in[0].auxen_pin = 1'h1;
        slot_in[0].oc = 5'h10;
        settle();
        slot_in[0].oc = 5'h00;
        check({5'h0, slot_out[0]}, 8'h00);
        slot_in[0].auxen_pin = 1'h0;
        settle();
        check({5'h0, slot_out[0]}, 8'h01);
        wreg(SPC_CMD_STAT_A, 8'h12);
        check({7'h0, int_n}, 8'h01);
        // a foreign address is not acknowledged and writes nothing
        u_spc_host.wr(sa ^ 7'h01, SPC_CMD_CTRL_A, 8'h03, ok);
        check({7'h0, ok}, 8'h00);
        rexp(SPC_CMD_CTRL_A, 8'h00);
        final_report();
    end
endmodule // testbench
